// [rtl/fpec_cfg.svh]
// constants of the flash program/erase controller
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH

`define FPEC_ADR_CONTROL 4'h0
`define FPEC_ADR_KEY 4'h4
`define FPEC_ADR_PAGE 4'h8
`define FPEC_ADR_OFFSET 4'hc

`define FPEC_BIT_START 15
`define FPEC_BIT_ALLOW 14
`define FPEC_BIT_FAULT 13
`define FPEC_BIT_ERASE 6
`define FPEC_CTRL_RESET 16'h0000
`define FPEC_CTRL_MASK 16'he04f

`define FPEC_KEY_FIRST 16'h0055
`define FPEC_KEY_SECOND 16'h00aa

`define FPEC_OP_BULK 4'hf
`define FPEC_OP_WORD 4'h3
`define FPEC_OP_BLOCK 4'h2
`define FPEC_OP_ROW 4'h1

`define FPEC_ROW_WORDS 64
`define FPEC_BLOCK_ROWS 8
`define FPEC_CLK_MHZ 20
`define FPEC_T_WORD_US 20
`define FPEC_T_ROW_US 20
`define FPEC_T_ERASE_US 20
`define FPEC_CYCLES(us) ((us) * `FPEC_CLK_MHZ)

`endif

// [rtl/fpec_pkg.sv]
// types of the flash program/erase controller
package fpec_pkg;
    typedef enum logic [3:0] {
        FPEC_IDLE = 4'b0001,
        FPEC_FIRST = 4'b0010,
        FPEC_ARMED = 4'b0100,
        FPEC_BUSY = 4'b1000
    } fpec_key_e;

    typedef enum logic [2:0] {
        FPEC_K_NONE = 3'h0,
        FPEC_K_WORD = 3'h1,
        FPEC_K_ROW = 3'h2,
        FPEC_K_BLOCK = 3'h3,
        FPEC_K_BULK = 3'h4
    } fpec_kind_e;
endpackage

// [rtl/fpec_timer.sv]
// self-timing counter for one flash operation
`timescale 1ns/1ps
module fpec_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } fpec_tmr_s;

    fpec_tmr_s r;
    fpec_tmr_s next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (load) begin
            next_r.cnt = count;
            next_r.run = 1'b1;
        end else if (r.run) begin
            if (r.cnt <= W'(1)) begin
                next_r.run = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.cnt = r.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule

// [rtl/fpec_top.sv]
// flash program/erase sequencer with wishbone register slave
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module fpec_top
    import fpec_pkg::*;
#(
    parameter int T_WORD = `FPEC_CYCLES(`FPEC_T_WORD_US),
    parameter int T_ROW = `FPEC_CYCLES(`FPEC_T_ROW_US),
    parameter int T_ERASE = `FPEC_CYCLES(`FPEC_T_ERASE_US),
    parameter int AW = 24
) (
    // clock and power-on reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // mode strap
    input wire logic SERIAL_MODE,
    // core and flash array
    output logic CORE_STALL,
    output logic FLASH_WORD,
    output logic FLASH_ROW,
    output logic FLASH_ERASE_BLOCK,
    output logic FLASH_ERASE_BULK,
    output logic [AW-1:0] FLASH_ADDR
);
    typedef struct packed {
        fpec_key_e key;
        fpec_kind_e kind;
        logic start;
        logic allow;
        logic fault;
        logic erase;
        logic [3:0] op;
        logic [7:0] page;
        logic [15:0] offset;
        logic [31:0] rdata;
        logic ack;
        logic stall;
        logic f_word;
        logic f_row;
        logic f_blk;
        logic f_bulk;
        logic [AW-1:0] faddr;
    } fpec_state_s;

    localparam int TW = 16;

    fpec_state_s r;
    fpec_state_s next_r;
    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_done;
    logic req;
    logic wr;
    logic [15:0] wd;
    logic [15:0] ctrl_view;
    fpec_kind_e pick;
    logic [AW-1:0] target;

    assign req = CYC_I & STB_I & ~r.ack;
    assign wr = req & WE_I & SEL_I[0] & SEL_I[1];
    assign wd = DAT_I[15:0];
    assign target = AW'({r.page, r.offset});

    // control view; unimplemented bits zero
    assign ctrl_view = {r.start, r.allow, r.fault, 6'h00, r.erase,
        2'b00, r.op} & `FPEC_CTRL_MASK;

    // decode operation from select, erase bit and, for bulk erase, the serial mode strap
    always_comb begin
        pick = FPEC_K_NONE;
        case (r.op)
            `FPEC_OP_WORD: if (!r.erase) pick = FPEC_K_WORD;
            `FPEC_OP_ROW: if (!r.erase) pick = FPEC_K_ROW;
            `FPEC_OP_BLOCK: if (r.erase) pick = FPEC_K_BLOCK;
            `FPEC_OP_BULK: begin
                if (r.erase && SERIAL_MODE) pick = FPEC_K_BULK;
            end
            default: pick = FPEC_K_NONE;
        endcase
    end

    always_comb begin
        next_r = r;
        tmr_load = 1'b0;
        tmr_count = '0;
        next_r.ack = req;
        next_r.f_word = 1'b0;
        next_r.f_row = 1'b0;
        next_r.f_blk = 1'b0;
        next_r.f_bulk = 1'b0;
        if (req && !WE_I) begin
            case (ADR_I)
                `FPEC_ADR_CONTROL: next_r.rdata = {16'h0000, ctrl_view};
                `FPEC_ADR_PAGE: next_r.rdata = {24'h000000, r.page};
                `FPEC_ADR_OFFSET: next_r.rdata = {16'h0000, r.offset};
                default: next_r.rdata = 32'h00000000;
            endcase
        end
        case (r.key)
            FPEC_IDLE: begin
                if (wr && ADR_I == `FPEC_ADR_KEY
                        && wd == `FPEC_KEY_FIRST) begin
                    next_r.key = FPEC_FIRST;
                end
            end
            FPEC_FIRST: begin
                if (wr) begin
                    if (ADR_I == `FPEC_ADR_KEY
                            && wd == `FPEC_KEY_SECOND) begin
                        next_r.key = FPEC_ARMED;
                    end else begin
                        next_r.key = FPEC_IDLE;
                    end
                end
            end
            FPEC_ARMED: begin
                if (wr && ADR_I != `FPEC_ADR_CONTROL) begin
                    next_r.key = FPEC_IDLE;
                end
            end
            FPEC_BUSY: begin
                if (tmr_done) begin
                    next_r.key = FPEC_IDLE;
                    next_r.start = 1'b0;
                    next_r.stall = 1'b0;
                    next_r.fault = 1'b0;
                    next_r.kind = FPEC_K_NONE;
                end
            end
            default: next_r.key = FPEC_IDLE;
        endcase
        if (wr && r.key != FPEC_BUSY) begin
            if (ADR_I == `FPEC_ADR_PAGE) next_r.page = wd[7:0];
            if (ADR_I == `FPEC_ADR_OFFSET) next_r.offset = wd;
            if (ADR_I == `FPEC_ADR_CONTROL) begin
                next_r.allow = wd[`FPEC_BIT_ALLOW];
                next_r.erase = wd[`FPEC_BIT_ERASE];
                next_r.op = wd[3:0];
                if (!wd[`FPEC_BIT_START]) begin
                    next_r.fault = wd[`FPEC_BIT_FAULT];
                end
                if (wd[`FPEC_BIT_START]) begin
                    next_r.key = FPEC_IDLE;
                    if (r.key == FPEC_ARMED && wd[`FPEC_BIT_ALLOW]
                            && r.allow) begin
                        next_r.start = 1'b1;
                        next_r.stall = 1'b1;
                        next_r.key = FPEC_BUSY;
                        next_r.kind = pick;
                        tmr_load = 1'b1;
                        case (pick)
                            FPEC_K_WORD: begin
                                next_r.f_word = 1'b1;
                                next_r.faddr = target;
                                tmr_count = TW'(T_WORD);
                            end
                            FPEC_K_ROW: begin
                                next_r.f_row = 1'b1;
                                next_r.faddr = target
                                    - target % AW'(2 * `FPEC_ROW_WORDS);
                                tmr_count = TW'(T_ROW);
                            end
                            FPEC_K_BLOCK: begin
                                next_r.f_blk = 1'b1;
                                next_r.faddr = target - target
                                    % AW'(2 * `FPEC_ROW_WORDS
                                    * `FPEC_BLOCK_ROWS);
                                tmr_count = TW'(T_ERASE);
                            end
                            FPEC_K_BULK: begin
                                next_r.f_bulk = 1'b1;
                                next_r.faddr = '0;
                                tmr_count = TW'(T_ERASE);
                            end
                            default: tmr_count = TW'(1);
                        endcase
                    end else begin
                        next_r.fault = 1'b1;
                    end
                end
            end
        end
    end

    fpec_timer #(
        .W(TW)
    ) u_timer (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            r <= '0;
            r.key <= FPEC_IDLE;
            r.kind <= FPEC_K_NONE;
        end else begin
            r <= next_r;
        end
    end

    assign DAT_O = r.rdata;
    assign ACK_O = r.ack;
    assign CORE_STALL = r.stall;
    assign FLASH_WORD = r.f_word;
    assign FLASH_ROW = r.f_row;
    assign FLASH_ERASE_BLOCK = r.f_blk;
    assign FLASH_ERASE_BULK = r.f_bulk;
    assign FLASH_ADDR = r.faddr;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    // longest timed operation plus launch and done cycles
    localparam int T_LONG = T_WORD > T_ROW ? T_WORD : T_ROW;
    localparam int STALL_MAX = (T_LONG > T_ERASE ? T_LONG : T_ERASE) + 2;

    sequence key_pair_s;
        r.key == FPEC_ARMED;
    endsequence

    sequence launch_s;
        $rose(r.start);
    endsequence

    sequence pulse_s;
        FLASH_WORD || FLASH_ROW || FLASH_ERASE_BLOCK || FLASH_ERASE_BULK;
    endsequence

    sequence stray_s;
        r.key == FPEC_FIRST && wr && ADR_I != `FPEC_ADR_KEY;
    endsequence

    stall_tracks_start_a: assert property (CORE_STALL == r.start)
        else $error("stall differs from start bit");
    stall_busy_a: assert property (
        CORE_STALL == (r.key == FPEC_BUSY))
        else $error("stall differs from busy state");
    start_needs_key_a: assert property (
        launch_s |-> $past(r.key) == FPEC_ARMED)
        else $error("start without unlock");
    no_sw_clear_a: assert property (r.start && !tmr_done |=> r.start)
        else $error("start bit cleared early");
    done_clears_a: assert property (tmr_done |=> !r.start)
        else $error("start bit not cleared at end");
    no_op_inhibit_a: assert property (
        launch_s |-> $past(r.allow))
        else $error("operation while inhibited");
    bad_start_fault_a: assert property (
        wr && ADR_I == `FPEC_ADR_CONTROL && wd[`FPEC_BIT_START]
        && r.key != FPEC_ARMED && r.key != FPEC_BUSY
        |=> r.fault && !r.start)
        else $error("bad start not flagged");
    reserved_zero_a: assert property (
        (ctrl_view & 16'h1fb0) == 16'h0000)
        else $error("reserved bits nonzero");
    key_consumed_a: assert property (
        key_pair_s ##1 launch_s |-> r.key == FPEC_BUSY ##1 1'b1)
        else $error("unlock not consumed");
    bulk_serial_a: assert property (
        FLASH_ERASE_BULK |-> $past(SERIAL_MODE))
        else $error("bulk erase outside serial mode");
    block_align_a: assert property (
        FLASH_ERASE_BLOCK |-> FLASH_ADDR
        % AW'(2 * `FPEC_ROW_WORDS * `FPEC_BLOCK_ROWS) == '0)
        else $error("erase block misaligned");
    row_align_a: assert property (
        FLASH_ROW |-> FLASH_ADDR % AW'(2 * `FPEC_ROW_WORDS) == '0)
        else $error("row misaligned");
    pulse_launch_a: assert property (pulse_s |-> launch_s)
        else $error("flash pulse without launch");
    one_pulse_a: assert property (
        $onehot0({FLASH_WORD, FLASH_ROW,
        FLASH_ERASE_BLOCK, FLASH_ERASE_BULK}))
        else $error("two flash operations at once");
    row_once_a: assert property (FLASH_ROW |=> !FLASH_ROW)
        else $error("row program pulse too long");
    word_code_a: assert property (
        FLASH_WORD |-> !r.erase && r.op == `FPEC_OP_WORD)
        else $error("word program with wrong code");
    row_code_a: assert property (
        FLASH_ROW |-> !r.erase && r.op == `FPEC_OP_ROW)
        else $error("row program with wrong code");
    block_code_a: assert property (
        FLASH_ERASE_BLOCK |-> r.erase && r.op == `FPEC_OP_BLOCK)
        else $error("block erase with wrong code");
    bulk_code_a: assert property (
        FLASH_ERASE_BULK |-> r.erase && r.op == `FPEC_OP_BULK)
        else $error("bulk erase with wrong code");
    stall_ends_a: assert property (
        launch_s |-> ##[1:STALL_MAX] !r.start)
        else $error("operation never finished");
    busy_locked_a: assert property (
        r.key == FPEC_BUSY |=> $stable(r.op) && $stable(r.erase)
        && $stable(r.allow) && $stable(r.page) && $stable(r.offset))
        else $error("register changed while busy");
    stray_drop_a: assert property (stray_s |=> r.key == FPEC_IDLE)
        else $error("partial unlock kept");
    armed_from_first_a: assert property (
        $rose(r.key == FPEC_ARMED) |-> $past(r.key) == FPEC_FIRST)
        else $error("unlock without both keys");
    end_clears_fault_a: assert property (
        r.key == FPEC_BUSY && tmr_done |=> !r.fault && !CORE_STALL)
        else $error("fault left after normal end");
endmodule

// [tb/fpec_core_model.sv]
// wishbone master standing in for the processor core
`timescale 1ns/1ps
module fpec_core_model (
    // clock
    input wire logic clk,
    // request from the bench
    input wire logic req,
    input wire logic we,
    input wire logic [3:0] adr,
    input wire logic [15:0] wdat,
    output logic [15:0] rdat,
    output logic done,
    // wishbone master
    output logic cyc,
    output logic stb,
    output logic wb_we,
    output logic [3:0] wb_adr,
    output logic [3:0] sel,
    output logic [31:0] dat_w,
    input wire logic [31:0] dat_r,
    input wire logic ack
);
    initial begin
        {cyc, stb, wb_we, wb_adr, sel, dat_w, done, rdat} = '0;
    end
    always @(posedge clk) begin
        done <= 1'b0;
        if (cyc && ack) begin
            rdat <= dat_r[15:0];
            cyc <= 1'b0;
            stb <= 1'b0;
            // released lines show a changed pattern
            wb_adr <= ~wb_adr;
            dat_w <= ~dat_w;
            sel <= ~sel;
            done <= 1'b1;
        end else if (req && !cyc && !done) begin
            cyc <= 1'b1;
            stb <= 1'b1;
            wb_we <= we;
            wb_adr <= adr;
            sel <= 4'hf;
            dat_w <= {16'h0000, wdat};
        end
    end
endmodule

// [tb/test_fpec_top.sv]
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
module test_fpec_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic serial_mode = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [15:0] wdat = 16'h0000;
    logic [15:0] rdat, q0;
    logic done, cyc, stb, wb_we, ack;
    logic [3:0] wb_adr, sel, seen;
    logic [31:0] dat_w, dat_r;
    logic stall, f_word, f_row, f_blk, f_bulk;
    logic [23:0] f_addr, cap_addr;
    int npulse, nstall, tno;
    int fails = 0;
    int samples_checked = 0;
    int seed = 82;

    fpec_top #(.T_WORD(4), .T_ROW(4), .T_ERASE(4)) fpec_top_inst (
        .CLK_SYS(clk_sys), .NRST(nrst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(wb_we), .ADR_I(wb_adr), .SEL_I(sel), .DAT_I(dat_w),
        .DAT_O(dat_r), .ACK_O(ack), .SERIAL_MODE(serial_mode),
        .CORE_STALL(stall), .FLASH_WORD(f_word), .FLASH_ROW(f_row),
        .FLASH_ERASE_BLOCK(f_blk), .FLASH_ERASE_BULK(f_bulk),
        .FLASH_ADDR(f_addr));
    fpec_core_model fpec_core_model_inst (
        .clk(clk_sys), .req(req), .we(we), .adr(adr), .wdat(wdat),
        .rdat(rdat), .done(done), .cyc(cyc), .stb(stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r),
        .ack(ack));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // launch pulses and stall cycles
    always @(posedge clk_sys) begin
        if (stall === 1'b1) nstall++;
        if ({f_bulk, f_blk, f_row, f_word} !== 4'h0) begin
            seen |= {f_bulk, f_blk, f_row, f_word};
            npulse++;
            cap_addr = f_addr;
        end
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        we <= w;
        adr <= a;
        wdat <= d;
        req <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) fails++;
        req <= 1'b0;
        q = rdat;
    endtask
    function automatic logic [3:0] exp_kind(input logic e,
                                            input logic [3:0] op);
        case ({e, op})
            5'h03: return 4'h1;
            5'h01: return 4'h2;
            5'h12: return 4'h4;
            5'h1f: return {serial_mode, 3'h0};
            default: return 4'h0;
        endcase
    endfunction
    // keys: 0 none, 1 good, 2 wrong key, 3 stray write, 4 no allow,
    // 5 no keys right after a used unlock
    task automatic run(input logic e, input logic [3:0] op, input int keys);
        logic [15:0] c, q, pg, of, m, x;
        logic [3:0] k;
        logic [23:0] ea;
        int n;
        pg = 16'($random(seed)) & 16'h00ff;
        of = 16'($random(seed));
        c = {1'b0, keys != 4, 7'h00, e, 2'h0, op};
        if (keys != 5) bus(1, 4'h8, pg, q);
        if (keys != 5) bus(1, 4'hc, of, q);
        bus(1, 4'h0, c | (16'($random(seed)) & 16'h1fb0), q);
        seen = 4'h0;
        npulse = 0;
        nstall = 0;
        if (keys inside {[1:4]}) bus(1, 4'h4, keys == 2 ? 16'h56 : 16'h55, q);
        if (keys == 3) bus(1, 4'h8, pg, q);
        if (keys inside {[1:4]}) bus(1, 4'h4, 16'h00aa, q);
        bus(1, 4'h0, c | 16'h8000, q);
        repeat (2) @(posedge clk_sys);
        n = 0;
        q = 16'h8000;
        while (q[15] !== 1'b0 && n < 50) begin
            bus(0, 4'h0, 16'h0000, q);
            n++;
        end
        k = (keys == 1) ? exp_kind(e, op) : 4'h0;
        check(seen, k);
        check(npulse, k != 0);
        m = (keys == 1 && k == 0) ? 16'hdfff : 16'hffff;
        x = c | (keys == 1 ? 16'h0000 : 16'h2000);
        check(q & m, x);
        if (k != 0) check(nstall >= 4, 1);
        else if (keys != 1) check(nstall, 0);
        m = (k == 2) ? 16'hff80 : (k == 4) ? 16'hfc00 : 16'hffff;
        ea = {pg[7:0], of & m};
        if (k != 0 && k != 4'h8) check(cap_addr, ea);
        tno++;
        $display("test %0d done e=%0d op=%h keys=%0d", tno, e, op, keys);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        tno = 0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(0, 4'h0, 16'h0000, q0);
        check(q0, 16'h0000);
        for (int i = 0; i < 32; i++) run(i[4], i[3:0], 1);
        @(posedge clk_sys);
        serial_mode <= 1'b0;
        run(1, 4'hf, 1);
        run(0, 4'h3, 0);
        for (int j = 2; j < 5; j++) run(0, 4'h1, j);
        run(1, 4'h2, 1);
        run(1, 4'h2, 5);
        stop_test();
    end
    initial begin
        #(50 * 40000);
        fails++;
        stop_test();
    end
endmodule
